/* src/lib_consts.vh */
`ifndef LIB_CONSTS_VH
`define LIB_CONSTS_VH
// Own register block (not forwarded)
`define LIB_OWN_LO 16'h0c80
`define LIB_OWN_HI 16'h0cbf
// Serial port span and default bases
`define LIB_COM_SPAN 16'h0007
`define LIB_COMA_DEF 4'h8
`define LIB_COMB_DEF 4'h7
// Memory window forwarded to the expansion bus
`define LIB_MEM_LO 24'h0a0000
`define LIB_MEM_HI 24'h0b7fff
// Supported interrupt lines (bit n = line n)
`define LIB_IRQ_OK 16'h9ef8
// Register offsets inside the own block
`define LIB_REG_CTRL 16'h0c80
`define LIB_REG_IRQEN 16'h0c82
`define LIB_REG_STAT 16'h0c84
// Control field positions
`define LIB_CTRL_AEN 0
`define LIB_CTRL_BEN 1
`define LIB_CTRL_ASEL 2
`define LIB_CTRL_BSEL 6
// Strobe timing, in ns and in counts of sys_clk cycles
`define LIB_STB_NS 32'd500
`define LIB_STB_CYC 8'd63
`define LIB_SET_CYC 8'd13
`endif

/* src/lib_bridge.v */
`timescale 1ns/100ps
`include "lib_consts.vh"
// How it works
// - Bridge alone masters bus, ownership request ignored
// - Refresh output held high, never driven
// - All seven DMA acknowledges high, requests ignored
// - Terminal count output held low
// - Runs byte-wide and word-wide I/O cycles
// - Forward I/O only if nobody upstream claims address
// - Own register range served internally, never forwarded
// - Two serial ports enabled, default standard ranges
// - Default free ranges are forwarded
// - Serial bases from ten choices, block 8 bytes
// - Memory forwarded only inside legacy window
// - Only lines 3-7,9-12,15 passed
// - Per-line enable, cleared at reset
// - Lines unshared, no sharing logic
module lib_bridge (
  input wire sys_clk,
  input wire rstn,
  input wire reqValid,
  input wire reqIsMem,
  input wire reqWrite,
  input wire reqWord,
  input wire [23:0] reqAddr,
  input wire [15:0] reqWdata,
  input wire reqClaimed,
  output wire reqBusy,
  output reg ackValid,
  output reg ackLocal,
  output reg [15:0] ackRdata,
  input wire [15:0] regAddr,
  input wire [15:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [15:0] regRdata,
  output reg [23:0] isaAddr,
  output reg isaAen,
  output reg isaSbhen,
  output reg isaIorn,
  output reg isaIown,
  output reg isaMemrn,
  output reg isaMemwn,
  output reg [15:0] isaDout,
  output reg isaDoe,
  input wire [15:0] isaDin,
  input wire isaIocs16n,
  input wire isaMastern,
  input wire [6:0] isaDrq,
  output wire [6:0] isaDackn,
  output wire isaRefreshn,
  output wire isaTc,
  input wire [15:0] isaIrq,
  output wire [15:0] hostIrq,
  output wire comAHit,
  output wire comBHit
);
  localparam S_IDLE = 4'b0001;
  localparam S_SET = 4'b0010;
  localparam S_STB = 4'b0100;
  localparam S_DONE = 4'b1000;
  // Upstream side of the engine
  // A request is taken on a rising edge with reqValid high while
  // reqBusy is low. The engine never queues, so a request offered
  // while busy is dropped without any answer; the host side must
  // wait for reqBusy to fall before it offers the next one.
  // A request that stays inside the block is answered one cycle
  // later with ackValid and ackLocal together and zero read data.
  // A forwarded request is answered once the expansion cycle ends.
  // ackValid stands for one cycle only, so whoever waits for it
  // must sample every cycle.
  //
  // Expansion side timing
  // Every forwarded cycle first drives address, byte-high enable
  // and write data, then lets them settle for a fixed count of
  // cycles before the command strobe falls. The strobe then stands
  // for a fixed count of cycles and rises again. Both counts are
  // fixed rather than stretched by the module, so slow modules are
  // a limitation: there is no ready line in this engine.
  //
  // Word-wide cycles
  // The 16-bit select from the module is looked at only on the
  // last settle cycle, when the address has been stable for the
  // whole settle time. Sampling earlier would risk a decode that
  // is still moving. An I/O module that answers keeps a single word
  // cycle; a memory word, or one that does not answer, gets two byte cycles, the low byte at
  // the even address first, the high byte next at the odd address,
  // both moved on the low data lanes.
  //
  // Memory cycles
  // Only the legacy window is forwarded. Any other memory address
  // is answered locally so the host never waits on a dead bus.
  //
  // Decode priority
  // Memory requests use only the window test. I/O requests stay
  // inside when the own register block, an enabled serial port or
  // an upstream claimer owns the address. Everything else goes out.
  // The upstream claim is a level that must stand with the request.
  //
  // Serial ports
  // Each port has an enable bit and a four-bit base select. Select
  // codes nine and above all map to the last legacy base, so a
  // stray value still lands on a legal base instead of on zero.
  //
  // Interrupts
  // Lines pass straight through, masked by the enable word and by
  // the fixed set of supported lines. Unsupported enable bits can
  // never be set, so reading the enable word back shows software
  // which lines really exist. There is no latch on the way, so the
  // host sees each line as a level with no added delay.
  //
  // Unsupported bus features
  // Refresh, DMA acknowledges and terminal count are constants.
  // Ownership requests and DMA requests have no path into the
  // logic at all; the bridge can never give the bus away.
  //
  // Reset
  // The raw reset only feeds the two-flop release; everything else
  // leaves reset on the synchronised copy, two edges after the pin
  // rises, which keeps the release free of recovery hazards.
  //
  // Status word
  // The status register holds the low 16 bits of the last forwarded
  // address, handy when tracing which module a driver talked to.
  reg rstMeta, rstSync;
  reg [3:0] state;
  reg [7:0] cnt;
  reg hiPhase, splitOp, isMem, isWr;
  reg [15:0] rdBuf, wrBuf;
  reg [15:0] ctrl, irqEn;
  reg [15:0] lastAddr;
  wire [15:0] ioA = reqAddr[15:0];
  // Reset released through two flops
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end
  // Ten legacy serial bases, indexed by a 4-bit select
  function [15:0] comBase;
    input [3:0] sel;
    begin
      case (sel)
        4'h0: comBase = 16'h0200;
        4'h1: comBase = 16'h0208;
        4'h2: comBase = 16'h0220;
        4'h3: comBase = 16'h0228;
        4'h4: comBase = 16'h0238;
        4'h5: comBase = 16'h02e8;
        4'h6: comBase = 16'h0338;
        4'h7: comBase = 16'h02f8;
        4'h8: comBase = 16'h03f8;
        default: comBase = 16'h03e8;
      endcase
    end
  endfunction
  wire [15:0] baseA = comBase(ctrl[`LIB_CTRL_ASEL+3:`LIB_CTRL_ASEL]);
  wire [15:0] baseB = comBase(ctrl[`LIB_CTRL_BSEL+3:`LIB_CTRL_BSEL]);
  // Serial port decode, 8-byte windows
  assign comAHit = ctrl[`LIB_CTRL_AEN] && ioA >= baseA &&
    ioA <= baseA + `LIB_COM_SPAN && !reqIsMem;
  assign comBHit = ctrl[`LIB_CTRL_BEN] && ioA >= baseB &&
    ioA <= baseB + `LIB_COM_SPAN && !reqIsMem;
  wire ownHit = !reqIsMem && ioA >= `LIB_OWN_LO &&
    ioA <= `LIB_OWN_HI;
  wire memOk = reqAddr >= `LIB_MEM_LO && reqAddr <= `LIB_MEM_HI;
  // Claimed I/O stays off the expansion bus; memory uses only the window
  wire localHit = reqIsMem ? !memOk :
    (ownHit || comAHit || comBHit || reqClaimed);
  assign reqBusy = (state != S_IDLE);
  // Fixed inactive levels for unsupported features
  assign isaDackn = 7'h7f;
  assign isaRefreshn = 1'b1;
  assign isaTc = 1'b0;
  // Masking only; no sharing since each line has one driver
  assign hostIrq = isaIrq & irqEn & `LIB_IRQ_OK;
  // Register port: control, enables, and a status word
  always @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      ctrl <= {6'h00, `LIB_COMB_DEF, `LIB_COMA_DEF, 2'b11};
      irqEn <= 16'h0000;
      regRdata <= 16'h0000;
    end else begin
      if (regWrite && regAddr == `LIB_REG_CTRL)
        ctrl <= regWdata;
      if (regWrite && regAddr == `LIB_REG_IRQEN)
        irqEn <= regWdata & `LIB_IRQ_OK;
      case (regAddr)
        `LIB_REG_CTRL: regRdata <= regRead ? ctrl : 16'h0000;
        `LIB_REG_IRQEN: regRdata <= regRead ? irqEn : 16'h0000;
        `LIB_REG_STAT: regRdata <= regRead ? lastAddr : 16'h0000;
        default: regRdata <= 16'h0000;
      endcase
    end
  end
  // Cycle engine; the bridge never releases the bus, ownership
  // requests from modules have no path in here
  always @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      state <= S_IDLE;
      cnt <= 8'h00;
      hiPhase <= 1'b0;
      splitOp <= 1'b0;
      isMem <= 1'b0;
      isWr <= 1'b0;
      rdBuf <= 16'h0000;
      wrBuf <= 16'h0000;
      lastAddr <= 16'h0000;
      ackValid <= 1'b0;
      ackLocal <= 1'b0;
      ackRdata <= 16'h0000;
      isaAddr <= 24'h000000;
      isaAen <= 1'b0;
      isaSbhen <= 1'b1;
      isaIorn <= 1'b1;
      isaIown <= 1'b1;
      isaMemrn <= 1'b1;
      isaMemwn <= 1'b1;
      isaDout <= 16'h0000;
      isaDoe <= 1'b0;
    end else begin
      ackValid <= 1'b0;
      ackLocal <= 1'b0;
      case (state)
        S_IDLE: begin
          if (reqValid && localHit) begin
            ackValid <= 1'b1; // Kept local (own block, serial port, claim, off-window memory): no bus cycle
            ackLocal <= 1'b1;
            ackRdata <= 16'h0000;
          end else if (reqValid) begin
            isMem <= reqIsMem;
            isWr <= reqWrite;
            hiPhase <= 1'b0;
            wrBuf <= reqWdata;
            rdBuf <= 16'h0000;
            lastAddr <= ioA;
            isaAddr <= reqAddr;
            isaSbhen <= ~reqWord;
            isaDout <= reqWdata;
            isaDoe <= reqWrite;
            cnt <= `LIB_SET_CYC;
            state <= S_SET;
            splitOp <= reqWord;
          end
        end
        S_SET: begin
          // Address settle; width decided from the 16-bit select
          if (cnt == 8'h00) begin
            if (splitOp && !isMem && isaIocs16n == 1'b0)
              splitOp <= 1'b0;
            else if (splitOp)
              isaSbhen <= 1'b1;
            isaIorn <= ~(!isMem && !isWr);
            isaIown <= ~(!isMem && isWr);
            isaMemrn <= ~(isMem && !isWr);
            isaMemwn <= ~(isMem && isWr);
            cnt <= `LIB_STB_CYC;
            state <= S_STB;
          end else
            cnt <= cnt - 8'h01;
        end
        S_STB: begin
          if (cnt == 8'h00) begin
            isaIorn <= 1'b1;
            isaIown <= 1'b1;
            isaMemrn <= 1'b1;
            isaMemwn <= 1'b1;
            if (splitOp && !hiPhase) begin
              rdBuf[7:0] <= isaDin[7:0];
              hiPhase <= 1'b1;
              isaAddr <= isaAddr + 24'h000001;
              isaDout <= {wrBuf[15:8], wrBuf[15:8]};
              cnt <= `LIB_SET_CYC;
              state <= S_SET;
            end else begin
              if (hiPhase)
                rdBuf[15:8] <= isaDin[7:0];
              else
                rdBuf <= isaDin;
              state <= S_DONE;
            end
          end else
            cnt <= cnt - 8'h01;
        end
        S_DONE: begin
          isaDoe <= 1'b0;
          isaSbhen <= 1'b1;
          ackValid <= 1'b1;
          ackRdata <= rdBuf;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // lib_bridge

/* tb/lib_bridge_checker.sv */
`timescale 1ns/100ps
module lib_bridge_checker (
  input wire sys_clk,
  input wire rstn,
  input wire reqValid,
  input wire reqIsMem,
  input wire [23:0] reqAddr,
  input wire reqClaimed,
  input wire reqBusy,
  input wire ackValid,
  input wire ackLocal,
  input wire [23:0] isaAddr,
  input wire isaIorn,
  input wire isaMemrn,
  input wire [6:0] isaDackn,
  input wire isaRefreshn,
  input wire isaTc,
  input wire [15:0] hostIrq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Accepted request, and one aimed at the own register block
  wire take = reqValid && !reqBusy;
  wire own = take && !reqIsMem && reqAddr[15:0] >= 16'h0c80 &&
    reqAddr[15:0] <= 16'h0cbf;
  own_local_a: assert property (own |=> ackValid && ackLocal)
    else $error("own range forwarded");
  claim_local_a: assert property (take && reqClaimed |=> ackLocal)
    else $error("claimed address forwarded");
  strobe_width_a: assert property ($fell(isaIorn) |->
    ##63 !isaIorn ##1 isaIorn) else $error("read strobe width");
  mem_window_a: assert property (!isaMemrn |->
    isaAddr >= 24'h0a0000 && isaAddr <= 24'h0b7fff) else $error("mem out");
  irq_gate_a: assert property ((hostIrq & ~16'h9ef8) == 16'h0)
    else $error("unsupported irq passed");
  dack_idle_a: assert property (isaDackn == 7'h7f)
    else $error("dma ack active");
  refresh_idle_a: assert property (isaRefreshn)
    else $error("refresh active");
  tc_low_a: assert property (!isaTc)
    else $error("terminal count high");
endmodule // lib_bridge_checker
bind lib_bridge lib_bridge_checker lib_bridge_checker_inst (.*);

/* tb/lib_isa_model.sv */
`timescale 1ns/100ps
module lib_isa_model (
  input wire sys_clk,
  input wire [23:0] isaAddr,
  input wire isaIorn,
  input wire isaIown,
  input wire [15:0] isaDout,
  input wire [15:0] irqSet,
  output reg [15:0] isaDin = 16'h0,
  output wire isaIocs16n,
  output wire isaMastern,
  output wire [6:0] isaDrq,
  output wire [15:0] isaIrq,
  output reg [15:0] lastWr = 16'h0
);
  // Only 0x300-0x3af is a word-wide card; the rest answer bytes only
  wire wide = isaAddr[15:0] >= 16'h0300 && isaAddr[15:0] <= 16'h03af;
  assign isaIocs16n = !wide;
  assign isaMastern = 1'b1;
  assign isaDrq = 7'h7f;
  assign isaIrq = irqSet;
  // Undriven lanes toggle so a stale byte never passes for read data
  always @(posedge sys_clk) begin
    isaDin <= !isaIorn ? {wide ? ~isaAddr[7:0] : ~isaDin[15:8],
      isaAddr[7:0]} : ~isaDin;
    if (!isaIown) lastWr <= isaDout;
  end
endmodule // lib_isa_model

/* tb/lib_bridge_tb_top.sv */
`timescale 1ns/100ps
module lib_bridge_tb_top;
  reg sys_clk = 0, rstn = 0, reqValid = 0, reqIsMem = 0, reqWrite = 0;
  reg reqWord = 0, reqClaimed = 0, regWrite = 0, regRead = 0;
  reg [23:0] reqAddr = 0;
  reg [15:0] reqWdata = 0, regAddr = 0, regWdata = 0, irqSet = 0;
  wire reqBusy, ackValid, ackLocal, isaAen, isaSbhen, isaIorn, isaIown;
  wire isaMemrn, isaMemwn, isaDoe, isaIocs16n, isaMastern, isaRefreshn;
  wire isaTc, comAHit, comBHit;
  wire [15:0] ackRdata, regRdata, isaDout, isaDin, isaIrq, hostIrq, lastWr;
  wire [23:0] isaAddr;
  wire [6:0] isaDrq, isaDackn;
  integer mismatches = 0, comparisons = 0, i, k;
  localparam [191:0] ADR = {16'h0300, 16'h03af, 16'h0600, 16'h0c7f,
    16'h0cc0, 16'h0cf8, 16'h0c80, 16'h0cbf, 16'h03f8, 16'h03ff, 16'h02f8,
    16'h02ff};
  localparam [143:0] BASE = {16'h0200, 16'h0208, 16'h0220, 16'h0228,
    16'h0238, 16'h02e8, 16'h0338, 16'h02f8, 16'h03f8};
  always #4 sys_clk = ~sys_clk;
  lib_bridge lib_bridge_inst (.*);
  lib_isa_model lib_isa_model_inst (.*);
  task check(input string n, input [15:0] s, e);
    comparisons = comparisons + 1;
    if (s !== e) begin
      mismatches = mismatches + 1;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task rw(input [15:0] a, d);
    @(posedge sys_clk) regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk) regWrite <= 1'b0;
  endtask
  task rr(input string n, input [15:0] a, e);
    @(posedge sys_clk) regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk) regRead <= 1'b0;
    @(negedge sys_clk) check(n, regRdata, e);
  endtask
  // One upstream cycle; a word read also checks the assembled data
  task rq(input string n, input m, w, wd, input [23:0] a, input lo,
    input [15:0] e);
    @(posedge sys_clk) reqIsMem <= m;
    reqWrite <= w;
    reqWord <= wd;
    reqAddr <= a;
    reqValid <= 1'b1;
    @(posedge sys_clk) reqValid <= 1'b0;
    for (i = 0; i < 400 && ackValid !== 1'b1; i = i + 1) @(negedge sys_clk);
    if (i == 400) begin
      mismatches = mismatches + 1;
      stop_test;
    end
    check(n, {15'h0, ackLocal}, {15'h0, lo});
    if (!w && wd) check(n, ackRdata, e);
  endtask
  task t_reset;
    rr("ctrl reset", 16'h0c80, 16'h01e3);
    rr("irqen reset", 16'h0c82, 16'h0000);
    @(posedge sys_clk) reqAddr <= 24'h0002ff;
    @(negedge sys_clk) check("com b hit", {15'h0, comBHit}, 16'h1);
    check("aen low", {15'h0, isaAen}, 16'h0);
    @(posedge sys_clk) irqSet <= 16'hffff;
    @(negedge sys_clk) check("irq off", hostIrq, 16'h0000);
  endtask
  task t_irq;
    rw(16'h0c82, 16'hffff);
    rr("irqen mask", 16'h0c82, 16'h9ef8);
    check("irq all", hostIrq, 16'h9ef8);
    rw(16'h0c82, 16'h0020);
    rw(16'h0c86, 16'h0000);
    rr("irqen kept", 16'h0c82, 16'h0020);
    @(posedge sys_clk) irqSet <= 16'h0420;
    @(negedge sys_clk) check("irq one", hostIrq, 16'h0020);
  endtask
  // Free ranges go out, own block and default serial ports stay inside
  task t_ranges;
    for (k = 0; k < 12; k = k + 1)
      rq("io range", 0, 0, 0, {8'h0, ADR[191-16*k -: 16]}, k >= 6, 0);
    @(posedge sys_clk) reqClaimed <= 1'b1;
    rq("claimed", 0, 0, 0, 24'h000600, 1, 0);
    @(posedge sys_clk) reqClaimed <= 1'b0;
  endtask
  task t_word;
    rq("word wide", 0, 0, 1, 24'h000302, 0, 16'hfd02);
    rq("word split", 0, 0, 1, 24'h000602, 0, 16'h0302);
    @(posedge sys_clk) reqWdata <= 16'hbeef;
    rq("word wr", 0, 1, 1, 24'h000300, 0, 0);
    check("wr data", lastWr, 16'hbeef);
    rr("last addr", 16'h0c84, 16'h0300);
  endtask
  task t_com;
    for (k = 0; k < 9; k = k + 1) begin
      rw(16'h0c80, {6'h00, 4'h7, k[3:0], 2'h3});
      @(posedge sys_clk) reqAddr <= {8'h0, BASE[143-16*k -: 16] + 16'h7};
      @(negedge sys_clk) check("com a hit", {15'h0, comAHit}, 16'h1);
      rq("com a", 0, 0, 0, {8'h0, BASE[143-16*k -: 16]}, 1, 0);
    end
    rw(16'h0c80, 16'h01e2);
    rq("com a off", 0, 0, 0, 24'h0003f8, 0, 0);
  endtask
  task t_mem;
    rq("mem lo", 1, 0, 0, 24'h0a0000, 0, 0);
    rq("mem hi", 1, 0, 0, 24'h0b7fff, 0, 0);
    rq("mem below", 1, 0, 0, 24'h09ffff, 1, 0);
    rq("mem above", 1, 0, 0, 24'h0b8000, 1, 0);
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset;
    t_irq;
    t_ranges;
    t_word;
    t_com;
    t_mem;
    stop_test;
  end
endmodule // lib_bridge_tb_top
